// ==== rtl/wdog_pkg.sv ====
// constants for the window watchdog supply controller
// assumes a 50 MHz clock; all times become cycle counts here
package wdog_pkg;
   localparam int unsigned clk_hz = 50_000_000;
   // undervoltage filter, least time in ns
   localparam int unsigned uv_filter_ns = 2000;
   localparam int unsigned uv_filter_cycles = (uv_filter_ns * (clk_hz / 1_000_000) + 999) / 1000;
   // timing setting in nF of the equivalent delay capacitor
   localparam int unsigned timing_nf = 100;
   // coefficients in seconds per farad
   localparam int unsigned lower_coef = 130_000;
   localparam int unsigned upper_coef = 38_200;
   localparam int unsigned pulse_coef = 10_000;
   localparam int unsigned por_coef = 475_000;
   // cycles = coef * nf * 1e-9 * clk_hz = coef * nf / 20
   localparam int unsigned lower_cycles = lower_coef / 20 * timing_nf;
   localparam int unsigned upper_cycles = upper_coef / 20 * timing_nf;
   localparam int unsigned pulse_cycles = pulse_coef / 20 * timing_nf;
   localparam int unsigned por_cycles = por_coef / 20 * timing_nf;
   localparam int unsigned cnt_w = 32;
   localparam logic full_window_rst = 1'b1;
   typedef enum logic [2:0] {wd_normal, wd_slow, wd_fast, wd_high, wd_low} wd_class_t;
endpackage

// ==== rtl/heartbeat_if.sv ====
// carrier between the controller and its heartbeat classifier
// assumes one clock domain
interface heartbeat_if;
   logic in_window;
   wdog_pkg::wd_class_t cls;
   logic good_edge;
   modport meas (output in_window, output cls, output good_edge);
   modport ctrl (input in_window, input cls, input good_edge);
endinterface

// ==== rtl/heartbeat_meter.sv ====
// measures heartbeat falling-edge intervals and classifies them
// assumes heartbeat_s is already synchronised to clk
module heartbeat_meter #(
   parameter int unsigned min_cycles = wdog_pkg::upper_cycles,
   parameter int unsigned max_cycles = wdog_pkg::lower_cycles,
   parameter bit upper_check = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // heartbeat
   input wire logic heartbeat_s,
   heartbeat_if.meas hb
);
   initial begin
      if (min_cycles >= max_cycles) $error("heartbeat window empty");
   end
   logic prev_q, prev_d;
   logic [31:0] cnt_q, cnt_d;
   wdog_pkg::wd_class_t cls_q, cls_d;
   logic good_q, good_d;
   logic fall;
   always_comb begin
      fall = prev_q & ~heartbeat_s;
      prev_d = heartbeat_s;
      cls_d = cls_q;
      good_d = 1'b0;
      cnt_d = (cnt_q == 32'hffffffff) ? cnt_q : cnt_q + 32'h1;
      if (fall) begin
         cnt_d = 32'h0;
         if (upper_check && cnt_q < 32'(min_cycles)) begin
            cls_d = wdog_pkg::wd_fast;
         end else if (cnt_q <= 32'(max_cycles)) begin
            cls_d = wdog_pkg::wd_normal;
            good_d = 1'b1;
         end else begin
            cls_d = wdog_pkg::wd_slow;
         end
      end else if (cnt_q > 32'(max_cycles)) begin
         // no edge in time: stuck level decides the class
         cls_d = heartbeat_s ? wdog_pkg::wd_high : wdog_pkg::wd_low;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         prev_q <= 1'b0;
         cnt_q <= 32'h0;
         cls_q <= wdog_pkg::wd_low;
         good_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         cnt_q <= cnt_d;
         cls_q <= cls_d;
         good_q <= good_d;
      end
   end
   assign hb.cls = cls_q;
   assign hb.in_window = (cls_q == wdog_pkg::wd_normal);
   assign hb.good_edge = good_q;
endmodule

// ==== rtl/supply_control.sv ====
// window watchdog supply controller: output enable, sleep and reset
// assumes fault and regulation flags come from analog comparators
// Behaviour
// - reset when heartbeat interval leaves window
// - reset on watchdog, undervoltage or power-up
// - undervoltage counts only after 2 us
// - enable high keeps output on
// - enable low, heartbeat normal: output on
// - enable low, out of window: sleep
// - five heartbeat classes, non-normal violates
// - reset pulse train until good heartbeat
// - reset pulse width from timing setting
// - both window limits from one setting
// - option disables the upper frequency check
// - input overvoltage forces output off
// - over-temperature turns pass device off
// - timing measured on falling heartbeat edges
// - reset held until regulation and delay, then pulsed until window
module supply_control #(
   parameter int unsigned por_cycles = wdog_pkg::por_cycles,
   parameter int unsigned pulse_cycles = wdog_pkg::pulse_cycles,
   parameter int unsigned min_cycles = wdog_pkg::upper_cycles,
   parameter int unsigned max_cycles = wdog_pkg::lower_cycles,
   parameter bit upper_check = wdog_pkg::full_window_rst
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pins from the host
   input wire logic heartbeat_input,
   input wire logic enable,
   // analog condition flags
   input wire logic in_regulation,
   input wire logic overvoltage,
   input wire logic overtemp,
   // outputs
   output logic output_on,
   output logic sleep,
   output logic reset_n_out,
   output logic reset_n_oe
);
   initial begin
      if (pulse_cycles < 1 || por_cycles < 1) $error("counts must be positive");
   end
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [4:0] s1_q, s2_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         s1_q <= 5'h0;
         s2_q <= 5'h0;
      end else begin
         s1_q <= {heartbeat_input, enable, in_regulation, overvoltage, overtemp};
         s2_q <= s1_q;
      end
   end
   logic hb_s, en_s, reg_s, ov_s, ot_s;
   assign {hb_s, en_s, reg_s, ov_s, ot_s} = s2_q;
   heartbeat_if hb();
   heartbeat_meter #(
      .min_cycles(min_cycles),
      .max_cycles(max_cycles),
      .upper_check(upper_check)
   ) meter (
      .clk(clk),
      .srst(srst),
      .heartbeat_s(hb_s),
      .hb(hb)
   );
   // ----------------------------------------
   // undervoltage filter and power-up delay
   // ----------------------------------------
   logic [15:0] uv_cnt_q, uv_cnt_d;
   logic uv_q, uv_d;
   logic [31:0] por_cnt_q, por_cnt_d;
   logic por_busy;
   always_comb begin
      uv_cnt_d = 16'h0;
      uv_d = uv_q;
      if (!reg_s) begin
         uv_cnt_d = uv_cnt_q;
         if (uv_cnt_q < 16'(wdog_pkg::uv_filter_cycles)) begin
            uv_cnt_d = uv_cnt_q + 16'h1;
         end else begin
            uv_d = 1'b1;
         end
      end else if (por_cnt_q >= 32'(por_cycles)) begin
         uv_d = 1'b0;
      end
      por_cnt_d = por_cnt_q;
      if (uv_d && !reg_s) begin
         por_cnt_d = 32'h0;
      end else if (reg_s && por_cnt_q < 32'(por_cycles)) begin
         por_cnt_d = por_cnt_q + 32'h1;
      end
   end
   assign por_busy = (por_cnt_q < 32'(por_cycles));
   always_ff @(posedge clk) begin
      if (srst) begin
         uv_cnt_q <= 16'h0;
         uv_q <= 1'b0;
         por_cnt_q <= 32'h0;
      end else begin
         uv_cnt_q <= uv_cnt_d;
         uv_q <= uv_d;
         por_cnt_q <= por_cnt_d;
      end
   end
   // ----------------------------------------
   // watchdog reset pulse train
   // ----------------------------------------
   logic [31:0] pcnt_q, pcnt_d;
   logic phase_q, phase_d;
   logic viol;
   assign viol = !hb.in_window;
   always_comb begin
      pcnt_d = pcnt_q;
      phase_d = phase_q;
      if (!viol || por_busy) begin
         // start one step early so the first asserted half is full width
         pcnt_d = 32'hffffffff;
         phase_d = 1'b0;
      end else if (pcnt_q + 32'h1 >= 32'(pulse_cycles)) begin
         // equal low and high halves, width set by timing
         pcnt_d = 32'h0;
         phase_d = ~phase_q;
      end else begin
         pcnt_d = pcnt_q + 32'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         pcnt_q <= 32'h0;
         phase_q <= 1'b0;
         output_on <= 1'b0;
         sleep <= 1'b0;
         reset_n_oe <= 1'b1;
      end else begin
         pcnt_q <= pcnt_d;
         phase_q <= phase_d;
         // faults override enable and heartbeat
         output_on <= !ov_s && !ot_s && (en_s || !viol);
         sleep <= !en_s && viol;
         // open drain: drive low during undervoltage or power-up delay, and in alternate halves of a watchdog violation
         reset_n_oe <= uv_q || por_busy || (viol && !phase_d);
      end
   end
   assign reset_n_out = 1'b0;
endmodule

// ==== tb/supply_chk.sv ====
// checker on the supply controller ports
// assumes pulse_cycles 5, max_cycles 40 and a 100 cycle filter
module supply_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic heartbeat_input,
   input wire logic enable,
   input wire logic in_regulation,
   input wire logic overvoltage,
   input wire logic overtemp,
   input wire logic output_on,
   input wire logic sleep,
   input wire logic reset_n_out,
   input wire logic reset_n_oe
);
   logic [7:0] uv_q, uv_d, hb_q, hb_d;
   logic hb_last_q;
   // ---------------------------------------------
   // dip and idle counters, saturating
   // ---------------------------------------------
   always_comb begin
      uv_d = in_regulation ? 8'h00 : uv_q + 8'(uv_q != 8'hff);
      hb_d = (heartbeat_input != hb_last_q) ? 8'h00 : hb_q + 8'(hb_q != 8'hff);
   end
   always_ff @(posedge clk) begin
      uv_q <= srst ? 8'h00 : uv_d;
      hb_q <= srst ? 8'h00 : hb_d;
      hb_last_q <= heartbeat_input;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   AST_EN_ON: assert property ((enable && !overvoltage && !overtemp)[*5] |-> output_on)
      else $error("output off while enabled");
   AST_EN_AWAKE: assert property (enable[*4] |-> !sleep)
      else $error("sleep while enabled");
   AST_OV: assert property (overvoltage[*4] |-> !output_on)
      else $error("output on during overvoltage");
   AST_OT: assert property (overtemp[*4] |-> !output_on)
      else $error("output on during overtemperature");
   AST_SLEEP: assert property (sleep |-> !output_on)
      else $error("output on in sleep");
   AST_UV: assert property (uv_q > 8'd110 |-> reset_n_oe)
      else $error("no reset on long undervoltage");
   AST_WD: assert property (hb_q == 8'd60 |-> ##[0:12] reset_n_oe)
      else $error("no reset on stuck heartbeat");
   AST_PULSE: assert property ($rose(reset_n_oe) |-> reset_n_oe[*5])
      else $error("reset pulse too short");
   AST_OD: assert property (reset_n_out == 1'b0)
      else $error("open drain value not low");
   cover property ($rose(sleep));
   cover property ($fell(reset_n_oe));
   cover property (overvoltage && !output_on);
endmodule

bind supply_control supply_chk supply_chk_i (.*);

// ==== tb/host_model.sv ====
// host model: heartbeat with a falling edge every period cycles
// assumes period between 2 and 255; stopping holds the level
module host_model (
   input wire logic clk,
   input wire logic run,
   input wire logic [7:0] period,
   output logic heartbeat
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt = 8'h00;
   initial heartbeat = 1'b1;
   always @(posedge clk) begin
      cnt <= (run && cnt + 8'h01 < period) ? cnt + 8'h01 : 8'h00;
      if (run) heartbeat <= (cnt >= (period >> 1));
   end
endmodule

// ==== tb/testbench.sv ====
// testbench for the supply controller with small cycle counts
// assumes host_model and supply_chk are compiled alongside
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, srst = 1'b1, enable = 1'b1, in_regulation = 1'b1;
   logic overvoltage = 1'b0, overtemp = 1'b0, run = 1'b0;
   logic [7:0] period = 8'd20;
   logic [1:0] seen;
   logic heartbeat_input, output_on, sleep, reset_n_out, reset_n_oe;
   int num_errors = 0, total_checks = 0, n;
   always #10 clk = ~clk;
   host_model host_model_i (.clk(clk), .run(run), .period(period), .heartbeat(heartbeat_input));
   supply_control #(.por_cycles(50), .pulse_cycles(5), .min_cycles(10), .max_cycles(40))
      supply_control_i (.clk(clk), .srst(srst), .heartbeat_input(heartbeat_input),
      .enable(enable), .in_regulation(in_regulation), .overvoltage(overvoltage),
      .overtemp(overtemp), .output_on(output_on), .sleep(sleep),
      .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe));
   task automatic check(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // bounded wait on the reset pin level
   task automatic wait_oe(input logic v);
      n = 0;
      while (reset_n_oe !== v) begin
         @(negedge clk);
         n++;
         if (n > 400) begin
            num_errors++;
            test_done;
         end
      end
   endtask
   task automatic t_power_up;
      repeat (3) @(negedge clk);
      check(reset_n_oe, 1'b1);
      @(posedge clk) run <= 1'b1;
      wait_oe(1'b0);
      check(n >= 40, 1'b1);
      check(output_on, 1'b1);
   endtask
   task automatic t_fast;
      @(posedge clk) period <= 8'd6;
      wait_oe(1'b1);
      @(posedge clk) period <= 8'd20;
      repeat (80) @(negedge clk);
      check(reset_n_oe, 1'b0);
   endtask
   task automatic t_uv;
      @(posedge clk) in_regulation <= 1'b0;
      repeat (60) @(negedge clk);
      check(reset_n_oe, 1'b0);
      @(posedge clk) in_regulation <= 1'b1;
      repeat (10) @(negedge clk);
      @(posedge clk) in_regulation <= 1'b0;
      repeat (150) @(negedge clk);
      check(reset_n_oe, 1'b1);
      @(posedge clk) in_regulation <= 1'b1;
      repeat (20) @(negedge clk);
      check(reset_n_oe, 1'b1);
      wait_oe(1'b0);
   endtask
   task automatic t_faults;
      for (int i = 0; i < 2; i++) begin
         @(posedge clk) {overtemp, overvoltage} <= 2'(i + 1);
         repeat (5) @(negedge clk);
         check(output_on, 1'b0);
         @(posedge clk) {overtemp, overvoltage} <= 2'b00;
         repeat (5) @(negedge clk);
         check(output_on, 1'b1);
      end
   endtask
   task automatic t_sleep;
      @(posedge clk) enable <= 1'b0;
      repeat (30) @(negedge clk);
      check(output_on, 1'b1);
      @(posedge clk) run <= 1'b0;
      n = 0;
      while (sleep !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      check(sleep, 1'b1);
      check(output_on, 1'b0);
      seen = 2'b00;
      repeat (20) begin
         @(negedge clk);
         seen = seen | {reset_n_oe, ~reset_n_oe};
      end
      check(seen[0] & seen[1], 1'b1);
      @(posedge clk) enable <= 1'b1;
      run <= 1'b1;
      repeat (80) @(negedge clk);
      check(output_on, 1'b1);
      check(reset_n_oe, 1'b0);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      t_power_up;
      t_fast;
      t_uv;
      t_faults;
      t_sleep;
      test_done;
   end
endmodule
